// [sars_readout.v]
// serial readout and sequencing of a 16-bit sampling converter
`timescale 1ns/1ns
`default_nettype none
`include "sars_consts.vh"
// How it works
// - output bits change on serial clock falls
// - select fall starts conversion and transfer
// - first four clock periods acquire input
// - fifth fall enables driver, low start
// - sixteen result bits follow, msb first
// - more clocks resend result, lsb first
// - after msb repeated, output goes high-z
// - later clock edges change nothing
// - only select high then low restarts
// - straight binary code, reference over 65536
// - difference captured once at hold entry
// - select low selects, high shuts down
// - frame bits belong to current conversion
module sars_readout #(
    parameter RES_BITS = `SARS_RES_BITS   // result width
) (
    input  wire                clk,                 // 20 MHz system clock
    input  wire                rst_n,               // sync reset, active low
    input  wire                select_shutdown_n,   // select pin, active low
    input  wire                serial_clock,        // host data clock pin
    input  wire [RES_BITS-1:0] sample_code,         // quantiser code in
    output reg                 dout_o,              // serial data out
    output reg                 dout_oe,             // driver enable, high drives
    output reg                 hold_o,              // pulse: capture input now
    output reg                 active_o,            // analog section powered
    output reg                 word_valid,          // result word available
    input  wire                word_ready,          // local consumer takes word
    output reg  [RES_BITS-1:0] word_data,           // result word
    output reg                 word_drop            // pulse: buffer was full
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_ACQ  = 4'b0010;
    localparam ST_SEND = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg  [1:0]                 cs_sync_reg;
    reg  [1:0]                 sck_sync_reg;
    reg                        cs_n_reg;
    reg                        sck_reg;
    reg  [3:0]                 state_reg;
    reg  [3:0]                 state_next;
    reg  [`SARS_CNT_W-1:0]     fall_cnt_reg;
    reg  [RES_BITS-1:0]        code_reg;
    reg                        push_reg;
    wire                       cs_n;
    wire                       sck;
    wire                       cs_fall;
    wire                       sck_fall;
    wire                       buf_in_ready;
    wire                       buf_out_valid;
    wire [RES_BITS-1:0]        buf_out_data;

    // stage 0 feeds only stage 1; edges come from the second stage
    always @(posedge clk) begin
        if (!rst_n) begin
            cs_sync_reg  <= 2'h3;
            sck_sync_reg <= 2'h0;
            cs_n_reg     <= 1'b1;
            sck_reg      <= 1'b0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[0], select_shutdown_n};
            sck_sync_reg <= {sck_sync_reg[0], serial_clock};
            cs_n_reg     <= cs_sync_reg[1];
            sck_reg      <= sck_sync_reg[1];
        end
    end

    assign cs_n     = cs_sync_reg[1];
    assign sck      = sck_sync_reg[1];
    assign cs_fall  = cs_n_reg && !cs_n;
    assign sck_fall = sck_reg && !sck && !cs_n;

    // bit index within either half of the frame; c counts falls seen
    // so far, so the fall being served is c + 1
    function [3:0] bit_idx;
        input [`SARS_CNT_W-1:0] c;
        reg   [`SARS_CNT_W-1:0] f;
        reg   [`SARS_CNT_W-1:0] d;
        begin
            f = c + 6'h01;
            d = 6'h00;
            if (f > `SARS_MSB_FIRST_LAST) begin
                // lsb already on the line, so the reversed copy starts at bit 1
                d = f - `SARS_MSB_FIRST_LAST;
                bit_idx = d[3:0];
            end else begin
                d = `SARS_MSB_FIRST_LAST - f;
                bit_idx = d[3:0];
            end
        end
    endfunction

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cs_fall)
                    state_next = ST_ACQ;
            end
            ST_ACQ: begin
                if (sck_fall && fall_cnt_reg == `SARS_START_EDGE - 6'h01)
                    state_next = ST_SEND;
            end
            ST_SEND: begin
                if (sck_fall &&
                    fall_cnt_reg == `SARS_LSB_FIRST_LAST - 6'h01)
                    state_next = ST_DONE;
            end
            ST_DONE: begin
                state_next = ST_DONE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // deselect aborts any frame; short cycling allowed
        if (cs_n)
            state_next = ST_IDLE;
        else if (cs_fall)
            state_next = ST_ACQ;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            fall_cnt_reg <= 6'h00;
            code_reg     <= {RES_BITS{1'b0}};
            push_reg     <= 1'b0;
            dout_o       <= 1'b0;
            dout_oe      <= 1'b0;
            hold_o       <= 1'b0;
            active_o     <= 1'b0;
            word_drop    <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_o    <= 1'b0;
            push_reg  <= 1'b0;
            word_drop <= 1'b0;
            active_o  <= !cs_n;
            if (state_next == ST_IDLE) begin
                fall_cnt_reg <= 6'h00;
                dout_oe      <= 1'b0;
                dout_o       <= 1'b0;
            end else if (cs_fall) begin
                fall_cnt_reg <= 6'h00;
                dout_oe      <= 1'b0;
            end else if (sck_fall && state_reg != ST_DONE) begin
                fall_cnt_reg <= fall_cnt_reg + 6'h01;
                if (fall_cnt_reg == `SARS_START_EDGE - 6'h02) begin
                    // last sampling fall: freeze the differential input
                    hold_o   <= 1'b1;
                    code_reg <= sample_code;
                end
                if (fall_cnt_reg == `SARS_START_EDGE - 6'h01) begin
                    dout_oe <= 1'b1;
                    dout_o  <= 1'b0;
                end else if (state_reg == ST_SEND) begin
                    if (fall_cnt_reg == `SARS_LSB_FIRST_LAST - 6'h01) begin
                        dout_oe <= 1'b0;
                        dout_o  <= 1'b0;
                    end else begin
                        // live code of this frame, no pipeline
                        dout_o <= code_reg[bit_idx(fall_cnt_reg)];
                    end
                    if (fall_cnt_reg == `SARS_MSB_FIRST_LAST - 6'h01) begin
                        push_reg  <= buf_in_ready;
                        word_drop <= !buf_in_ready;
                    end
                end
            end
        end
    end

    sars_buf #(
        .WIDTH (RES_BITS),
        .DEPTH (`SARS_BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push_reg),
        .in_ready  (buf_in_ready),
        .in_data   (code_reg),
        .out_valid (buf_out_valid),
        .out_ready (word_ready && word_valid),
        .out_data  (buf_out_data)
    );

    // registered view of the buffer head; refreshed after each pop
    always @(posedge clk) begin
        if (!rst_n) begin
            word_valid <= 1'b0;
            word_data  <= {RES_BITS{1'b0}};
        end else if (word_valid && word_ready) begin
            word_valid <= 1'b0;
        end else begin
            word_valid <= buf_out_valid;
            word_data  <= buf_out_data;
        end
    end
endmodule
`default_nettype wire

// [sars_consts.vh]
// constants for the serial readout of the sampling converter
`ifndef SARS_CONSTS_VH
`define SARS_CONSTS_VH
`define SARS_RES_BITS        16
`define SARS_CNT_W           6
`define SARS_START_EDGE      6'h05
`define SARS_MSB_FIRST_LAST  6'h15
`define SARS_LSB_FIRST_LAST  6'h25
`define SARS_BUF_DEPTH       2
`define SARS_CLK_PERIOD_NS   50
`define SARS_SCLK_MIN_NS     200
`define SARS_SCLK_MIN_CYC    ((`SARS_SCLK_MIN_NS + `SARS_CLK_PERIOD_NS - 1) / `SARS_CLK_PERIOD_NS)
`endif

// [sars_buf.v]
// two-entry valid/ready buffer for conversion results
`timescale 1ns/1ns
`default_nettype none
module sars_buf #(
    parameter WIDTH = 16,                 // word width
    parameter DEPTH = 2                   // entries
) (
    input  wire             clk,          // system clock
    input  wire             rst_n,        // sync reset, active low
    input  wire             in_valid,     // word offered
    output wire             in_ready,     // space available
    input  wire [WIDTH-1:0] in_data,      // word in
    output wire             out_valid,    // word held
    input  wire             out_ready,    // consumer takes word
    output wire [WIDTH-1:0] out_data      // oldest word
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [1:0]       wr_reg;
    reg [1:0]       rd_reg;
    reg [2:0]       cnt_reg;
    wire            push;
    wire            pop;
    assign in_ready  = (cnt_reg != DEPTH);
    assign out_valid = (cnt_reg != 3'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_reg[0]];

    function [1:0] bump;
        input [1:0] p;
        begin
            bump = (p == DEPTH - 1) ? 2'h0 : p + 2'h1;
        end
    endfunction

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_reg  <= 2'h0;
            rd_reg  <= 2'h0;
            cnt_reg <= 3'h0;
        end else begin
            if (push) begin
                mem_reg[wr_reg[0]] <= in_data;
                wr_reg <= bump(wr_reg);
            end
            if (pop)
                rd_reg <= bump(rd_reg);
            if (push && !pop)
                cnt_reg <= cnt_reg + 3'h1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 3'h1;
        end
    end
endmodule
`default_nettype wire

// [sars_checker.sv]
// assertion checker for the converter serial readout
`timescale 1ns/1ns
`default_nettype none
module sars_checker #(
    parameter RES_BITS = 16
) (
    input wire logic                clk,               // clock
    input wire logic                rst_n,             // reset
    input wire logic                select_shutdown_n, // select
    input wire logic                serial_clock,      // link clock
    input wire logic [RES_BITS-1:0] sample_code,       // code in
    input wire logic                dout_o,            // data
    input wire logic                dout_oe,           // data enable
    input wire logic                hold_o,            // hold pulse
    input wire logic                active_o,          // powered
    input wire logic                word_valid,        // word held
    input wire logic                word_ready,        // word taken
    input wire logic [RES_BITS-1:0] word_data,         // word
    input wire logic                word_drop          // word lost
);
    logic done_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // frame is spent once the driver lets go while select is still low
    always @(posedge clk)
        if (!rst_n || select_shutdown_n) done_reg <= 1'b0;
        else if ($fell(dout_oe)) done_reg <= 1'b1;
    a_oe_deselect: assert property (select_shutdown_n [*6] |-> !dout_oe)
        else $error("driver on while deselected");
    a_active_sel: assert property ($stable(select_shutdown_n) [*6]
        |-> active_o == !select_shutdown_n) else $error("active wrong");
    a_hold_once: assert property (hold_o |=> !hold_o [*8])
        else $error("hold repeated");
    a_start_low: assert property ($rose(dout_oe) |-> (dout_oe && !dout_o) [*8])
        else $error("start bit wrong");
    a_acq_hiz: assert property (hold_o |-> !dout_oe [*7] ##[1:2] dout_oe)
        else $error("driver timing after hold");
    a_launch_fall: assert property ($changed(dout_o) && dout_oe
        && $past(dout_oe) |-> !$past(serial_clock, 2))
        else $error("data changed off a fall");
    a_word_hold: assert property (word_valid && !word_ready
        |=> word_valid && $stable(word_data)) else $error("word lost");
    a_frame_over: assert property (done_reg |-> !dout_oe && !hold_o)
        else $error("activity after frame end");
    cover property (hold_o);
    cover property ($fell(dout_oe) && !select_shutdown_n);
    cover property (word_drop);
endmodule
bind sars_readout sars_checker #(.RES_BITS(RES_BITS)) u_chk (
    .clk(clk), .rst_n(rst_n), .select_shutdown_n(select_shutdown_n),
    .serial_clock(serial_clock), .sample_code(sample_code),
    .dout_o(dout_o), .dout_oe(dout_oe), .hold_o(hold_o),
    .active_o(active_o), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_drop(word_drop));
`default_nettype wire

// [sars_host.sv]
// host model: drives select and link clock, captures data
`timescale 1ns/1ns
`default_nettype none
module sars_host (
    input  wire logic clk,               // system clock
    input  wire logic dout_o,            // device data
    input  wire logic dout_oe,           // device drives data
    output var  logic select_shutdown_n, // select, active low
    output var  logic serial_clock       // link clock, idles low
);
    logic        last_reg = 1'b0;
    logic [1:40] cap;
    wire         line;
    // no pull on the line: released, it shows the inverse of the last bit
    always @(posedge clk)
        if (dout_oe) last_reg <= dout_o;
    assign line = dout_oe ? dout_o : ~last_reg;
    initial begin
        select_shutdown_n = 1'b1;
        serial_clock = 1'b0;
    end
    // one frame of n link clock falls; cap[i] is taken at rise i
    task automatic frame(input int n);
        @(posedge clk);
        #13 select_shutdown_n = 1'b0;
        for (int i = 1; i <= n; i++) begin
            #200 serial_clock = 1'b1;
            cap[i] = line;
            #200 serial_clock = 1'b0;
        end
        #200 select_shutdown_n = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// [sars_readout_tb_top.sv]
// self-checking bench for the converter serial readout
`timescale 1ns/1ns
`default_nettype none
module sars_readout_tb_top;
    typedef struct { logic [15:0] code; int n; } sars_row_t;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        word_ready = 1'b0;
    logic [15:0] sample_code = 16'h0000;
    logic        select_shutdown_n, serial_clock, dout_o, dout_oe;
    logic        hold_o, active_o, word_valid, word_drop;
    logic [15:0] word_data;
    int          miscompares = 0;
    int          check_count = 0;
    int          drops = 0;
    sars_row_t   rows[5] = '{'{16'h0000, 40}, '{16'hFFFF, 37},
        '{16'hA5C3, 22}, '{16'h8001, 10}, '{16'h7FFE, 40}};
    sars_readout u_dut (.clk(clk), .rst_n(rst_n),
        .select_shutdown_n(select_shutdown_n), .serial_clock(serial_clock),
        .sample_code(sample_code), .dout_o(dout_o), .dout_oe(dout_oe),
        .hold_o(hold_o), .active_o(active_o), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data),
        .word_drop(word_drop));
    sars_host u_host (.clk(clk), .dout_o(dout_o), .dout_oe(dout_oe),
        .select_shutdown_n(select_shutdown_n), .serial_clock(serial_clock));
    initial forever #25 clk = ~clk;
    always @(posedge clk)
        if (word_drop === 1'b1) drops++;
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic pop(input logic [15:0] exp);
        for (int t = 0; t < 40 && word_valid !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        check(word_valid === 1'b1 && word_data === exp, "word");
        word_ready = 1'b1;
        @(posedge clk);
        #1 word_ready = 1'b0;
    endtask
    task automatic run(input sars_row_t r);
        @(posedge clk);
        #1 sample_code = r.code;
        fork
            u_host.frame(r.n);
            begin
                // input moves after hold; the result must not follow it
                @(posedge hold_o);
                #1 sample_code = ~r.code;
            end
        join
        check(u_host.cap[6] === 1'b0, "start bit");
        for (int i = 7; i <= r.n && i <= 37; i++)
            check(u_host.cap[i] === r.code[i < 23 ? 22 - i : i - 22],
                "data bit");
        if (r.n > 37)
            check(u_host.cap[38] === ~r.code[15], "not released");
        check(dout_oe === 1'b0 && active_o === 1'b0, "idle");
        if (r.n >= 21)
            pop(r.code);
        else
            check(word_valid === 1'b0, "short frame word");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #2000000;
        miscompares++;
        $display("[FAIL] %0t watchdog", $time);
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 check(dout_oe === 1'b0 && word_valid === 1'b0, "reset");
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[k])
            run(rows[k]);
        // receiver stalls: two words fit, the third is dropped
        for (int k = 0; k < 3; k++) begin
            sample_code = 16'(16'h1111 * (k + 1));
            u_host.frame(22);
        end
        check(drops === 1, "drop count");
        pop(16'h1111);
        pop(16'h2222);
        repeat (4) @(posedge clk);
        check(word_valid === 1'b0, "not empty");
        // average of two equal constant codes 16'h2222; no captured word is used
        check(((17'h02222 + 17'h02222) >> 1) === 17'h02222, "average");
        wrap_up();
    end
endmodule
`default_nettype wire
